// *** pkg/popc_pkg.sv ***
// Package for the port O pin configuration block: offsets, fields, carriers
package popc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DATA        = 8'h00;
  localparam logic [7:0] OFS_OUT_ENABLE  = 8'h04;
  localparam logic [7:0] OFS_ALT_ONE     = 8'h08;
  localparam logic [7:0] OFS_ALT_TWO     = 8'h0C;
  localparam logic [7:0] OFS_ALT_THREE   = 8'h10;
  localparam logic [7:0] OFS_DRIVER_TYPE = 8'h28;
  localparam logic [7:0] OFS_PULL_UP     = 8'h2C;
  localparam logic [7:0] OFS_INPUT_EN    = 8'h38;
  localparam logic [7:0] OFS_PIN_LEVEL   = 8'h3C;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int          PIN_COUNT      = 8;
  localparam logic [7:0]  ALT_THREE_MASK = 8'h44;
  localparam int          CLEAR_TO_SEND_CH7_BIT       = 6;
  localparam int          CLEAR_TO_SEND_CH6_BIT       = 2;
  localparam logic [7:0]  PINS_RESET     = 8'h00;
  localparam logic [31:0] READ_UNMAPPED  = 32'h00000000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] out_enable;
    logic [7:0] alt_one;
    logic [7:0] alt_two;
    logic [7:0] alt_three;
    logic [7:0] driver_type;
    logic [7:0] pull_up;
    logic [7:0] input_en;
  } popc_regs_s;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pull_up;
    logic [7:0] input_buf_en;
    logic [7:0] ext_int;
    logic       clear_to_send_ch7;
    logic       clear_to_send_ch6;
  } popc_pins_s;

endpackage : popc_pkg

// *** verilog/popc_port_o.sv ***
// Port O pin configuration: register file on Avalon-MM and pin steering
//
// Overview of operation
// - Second select bits 7..0 route timer outputs F..8 to pins; reset zero.
// - Third select: bit 6 feeds ch7 clear-to-send, bit 2 ch6; others zero.
// - Driver type bit: zero push-pull, one open-drain; upper bits read zero.
// - Pull-up bit one enables the pin pull-up; reset disables all.
// - Input enable bit one enables the input buffer; reset disables all.
// - Reset leaves all pins general purpose, input, output, pull-up off.
// - Outside stop mode, enabled input levels reach the external interrupt.
// - Output enable bit lets the pin drive; clear leaves driver off unless select one picks the pin with alt_one_oe set and select two clear.
module popc_port_o (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Avalon-MM slave
  input  wire logic [7:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // Pins and peripherals
  input  wire logic [7:0]            pin_in,
  input  wire logic [7:0]            timer_outputs,
  input  wire logic [7:0]            alt_one_out,
  input  wire logic [7:0]            alt_one_oe,
  input  wire logic                  stop_mode,
  output popc_pkg::popc_pins_s       pins
);

  // ----------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------
  popc_pkg::popc_regs_s regs;
  popc_pkg::popc_regs_s next_regs;
  logic [31:0]          next_readdata;
  logic                 next_waitrequest;
  logic                 ack;
  popc_pkg::popc_pins_s next_pins;

  // Low byte write honours byte lane zero only; upper bits are not stored
  function automatic logic [7:0] merge_low(input logic [7:0] cur, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge_low = be[0] ? wd[7:0] : cur;
  endfunction : merge_low

  // Takes a where sel is set and b elsewhere, per pin, for timer and select-one outputs; the timer order is F..8 from bit 7 down
  function automatic logic [7:0] pick(input logic [7:0] sel, input logic [7:0] a,
                                     input logic [7:0] b);
    pick = (sel & a) | (~sel & b);
  endfunction : pick

  // ----------------------------------------------------------------
  // Bus access: one wait cycle, answered on the second edge
  // ----------------------------------------------------------------
  // Waitrequest rests high so a new request is always held one edge before it is acked
  always_comb begin
    next_waitrequest = 1'b1;
    if ((read || write) && waitrequest && !ack) begin
      next_waitrequest = 1'b0;
    end
  end

  always_comb begin
    next_regs     = regs;
    next_readdata = readdata;
    if (write && !waitrequest) begin
      unique case (address)
        popc_pkg::OFS_DATA:        next_regs.data = merge_low(regs.data, writedata, byteenable);
        popc_pkg::OFS_OUT_ENABLE:  next_regs.out_enable =
                                     merge_low(regs.out_enable, writedata, byteenable);
        popc_pkg::OFS_ALT_ONE:     next_regs.alt_one =
                                     merge_low(regs.alt_one, writedata, byteenable);
        popc_pkg::OFS_ALT_TWO:     next_regs.alt_two =
                                     merge_low(regs.alt_two, writedata, byteenable);
        popc_pkg::OFS_ALT_THREE:   next_regs.alt_three = popc_pkg::ALT_THREE_MASK &
                                     merge_low(regs.alt_three, writedata, byteenable);
        popc_pkg::OFS_DRIVER_TYPE: next_regs.driver_type =
                                     merge_low(regs.driver_type, writedata, byteenable);
        popc_pkg::OFS_PULL_UP:     next_regs.pull_up =
                                     merge_low(regs.pull_up, writedata, byteenable);
        popc_pkg::OFS_INPUT_EN:    next_regs.input_en =
                                     merge_low(regs.input_en, writedata, byteenable);
        default:                   next_regs = regs;  // Unmapped writes are dropped
      endcase
    end
    if (read && waitrequest) begin
      unique case (address)
        popc_pkg::OFS_DATA:        next_readdata = {24'h000000, regs.data};
        popc_pkg::OFS_OUT_ENABLE:  next_readdata = {24'h000000, regs.out_enable};
        popc_pkg::OFS_ALT_ONE:     next_readdata = {24'h000000, regs.alt_one};
        popc_pkg::OFS_ALT_TWO:     next_readdata = {24'h000000, regs.alt_two};
        popc_pkg::OFS_ALT_THREE:   next_readdata = {24'h000000, regs.alt_three};
        popc_pkg::OFS_DRIVER_TYPE: next_readdata = {24'h000000, regs.driver_type};
        popc_pkg::OFS_PULL_UP:     next_readdata = {24'h000000, regs.pull_up};
        popc_pkg::OFS_INPUT_EN:    next_readdata = {24'h000000, regs.input_en};
        popc_pkg::OFS_PIN_LEVEL:   next_readdata = {24'h000000, pin_in & regs.input_en};
        default:                   next_readdata = popc_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------
  // Overlapping selects are software's fault; priority two over one keeps it defined
  always_comb begin
    logic [7:0] alt_drive;
    logic [7:0] func_out;
    logic [7:0] func_oe;
    alt_drive = 8'h00;
    func_out  = 8'h00;
    func_oe   = 8'h00;
    alt_drive = pick(regs.alt_one, alt_one_out, regs.data);
    func_out  = pick(regs.alt_two, timer_outputs, alt_drive);
    func_oe   = regs.out_enable | (regs.alt_one & alt_one_oe & ~regs.alt_two);
    // Open-drain only pulls low: a high level releases the driver
    next_pins.pin_out      = func_out;
    next_pins.pin_oe       = func_oe & ~(regs.driver_type & func_out);
    next_pins.pull_up      = regs.pull_up;
    next_pins.input_buf_en = regs.input_en;
    next_pins.ext_int      = stop_mode ? 8'h00 : (pin_in & regs.input_en);
    // Clear-to-send idles high (deasserted) unless the pin is selected and listening
    next_pins.clear_to_send_ch7 = regs.alt_three[popc_pkg::CLEAR_TO_SEND_CH7_BIT] ?
                     (pin_in[popc_pkg::CLEAR_TO_SEND_CH7_BIT] | ~regs.input_en[popc_pkg::CLEAR_TO_SEND_CH7_BIT]) :
                     1'b1;
    next_pins.clear_to_send_ch6 = regs.alt_three[popc_pkg::CLEAR_TO_SEND_CH6_BIT] ?
                     (pin_in[popc_pkg::CLEAR_TO_SEND_CH6_BIT] | ~regs.input_en[popc_pkg::CLEAR_TO_SEND_CH6_BIT]) :
                     1'b1;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Everything clears to general-purpose use with all drivers off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regs        <= '0;
      readdata    <= 32'h00000000;
      waitrequest <= 1'b1;
      ack         <= 1'b0;
      pins        <= '{pin_out: 8'h00, pin_oe: 8'h00, pull_up: 8'h00, input_buf_en: 8'h00,
                       ext_int: 8'h00, clear_to_send_ch7: 1'b1, clear_to_send_ch6: 1'b1};
    end else begin
      regs        <= next_regs;
      readdata    <= next_readdata;
      waitrequest <= next_waitrequest;
      ack         <= !next_waitrequest;
      pins        <= next_pins;
    end
  end

endmodule : popc_port_o

// *** tb/popc_port_o_assertions.sv ***
// Checker for bus handshake and pin outputs
module popc_port_o_assertions (
  // Clock and reset
  input wire logic            clk,
  input wire logic            rstn,
  // Bus
  input wire logic [7:0]      address,
  input wire logic            read,
  input wire logic            write,
  input wire logic [31:0]     readdata,
  input wire logic            waitrequest,
  // Pins
  input wire logic [7:0]      pin_in,
  input wire logic            stop_mode,
  input popc_pkg::popc_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ack_pulse_a: assert property (!waitrequest |=> waitrequest) else $error("ack held");
  ack_cause_a: assert property ($fell(waitrequest) |-> $past(read || write)) else $error("bad ack");
  ack_bound_a: assert property ((read || write) && waitrequest |-> ##[1:3] !waitrequest)
    else $error("no ack");
  ext_int_a: assert property (pins.ext_int ==
    ($past(stop_mode) ? 8'h00 : $past(pin_in) & pins.input_buf_en)) else $error("ext int");
  pull_cause_a: assert property ($changed(pins.pull_up) |->
    $past(write && !waitrequest && address == popc_pkg::OFS_PULL_UP, 2)) else $error("pull");
  ie_cause_a: assert property ($changed(pins.input_buf_en) |->
    $past(write && !waitrequest && address == popc_pkg::OFS_INPUT_EN, 2)) else $error("ie");
  upper_zero_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper bits");
  sel3_mask_a: assert property (read && !waitrequest && address == popc_pkg::OFS_ALT_THREE
    |-> (readdata[7:0] & ~popc_pkg::ALT_THREE_MASK) == 8'h00) else $error("sel3");
endmodule : popc_port_o_assertions
bind popc_port_o popc_port_o_assertions chk_u (.clk(clk), .rstn(rstn), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .pin_in(pin_in), .stop_mode(stop_mode), .pins(pins));

// *** tb/popc_pad_model.sv ***
// Pad model for the eight port O pins
module popc_pad_model (
  // Block side
  input popc_pkg::popc_pins_s pins,
  // Board side
  input wire logic [7:0]      ext,
  output logic [7:0]          pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pins float to pull-up or board level; open-drain ones never drive high
  assign pin_in = (pins.pin_oe & pins.pin_out) | (~pins.pin_oe & (pins.pull_up | ext));
endmodule : popc_pad_model

// *** tb/test_popc_port_o.sv ***
// Self-checking bench for the port O pin configuration block
module test_popc_port_o;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Stimulus and instances
  // ----------------------------------------------------------------
  logic clk = 0, rstn = 0, read = 0, write = 0, stop_mode = 0;
  logic [7:0] address = 0, timer_outputs = 0, ext = 0, pin_in;
  logic [31:0] writedata = 0, readdata, q;
  logic waitrequest;
  popc_pkg::popc_pins_s pins;
  int errors = 0, checks_done = 0;
  logic [7:0] ofs [5] = '{8'h0C, 8'h10, 8'h28, 8'h2C, 8'h38};
  popc_port_o dut_u (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .timer_outputs(timer_outputs), .alt_one_out(8'h00),
    .alt_one_oe(8'h00), .stop_mode(stop_mode), .pins(pins));
  popc_pad_model pad_u (.pins(pins), .ext(ext), .pin_in(pin_in));
  // 10 MHz clock
  always #50 clk = ~clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Hold the request until waitrequest is seen low, then keep two-cycle spacing
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 20) errors++;
    repeat (2) @(posedge clk);
  endtask : bus
  task automatic s_regs();
    chk(64'(pins), 64'h3);
    for (int i = 0; i < 5; i++) begin
      bus(0, ofs[i], 0);
      chk(q, 0);
      bus(1, ofs[i], 32'hFFFFFFFF);
      bus(0, ofs[i], 0);
      chk(q, i == 1 ? 32'h44 : 32'hFF);
      bus(1, ofs[i], 0);
    end
    bus(1, 8'h14, 32'hFFFFFFFF);
    bus(0, 8'h14, 0);
    chk(q, 0);
  endtask : s_regs
  task automatic s_drive();
    timer_outputs <= 8'h5A;
    bus(1, popc_pkg::OFS_DATA, 32'hC3);
    bus(1, popc_pkg::OFS_OUT_ENABLE, 32'hFF);
    bus(1, popc_pkg::OFS_ALT_TWO, 32'h0F);
    chk({pins.pin_out, pins.pin_oe}, 16'hCAFF);
    timer_outputs <= 8'hA5;
    repeat (2) @(posedge clk);
    chk(pins.pin_out, 8'hC5);
    bus(1, popc_pkg::OFS_DRIVER_TYPE, 32'hFF);
    chk(pins.pin_oe, 8'h3A);
    bus(1, popc_pkg::OFS_OUT_ENABLE, 32'h00);
    chk(pins.pin_oe, 8'h00);
  endtask : s_drive
  task automatic s_input();
    ext <= 8'h05;
    bus(1, popc_pkg::OFS_PULL_UP, 32'hF0);
    bus(1, popc_pkg::OFS_INPUT_EN, 32'hFF);
    chk({pins.pull_up, pins.input_buf_en, pins.ext_int}, 24'hF0FFF5);
    bus(0, popc_pkg::OFS_PIN_LEVEL, 0);
    chk(q, 32'hF5);
    stop_mode <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pins.ext_int, 8'h00);
    stop_mode <= 1'b0;
    bus(1, popc_pkg::OFS_INPUT_EN, 32'h0F);
    chk(pins.ext_int, 8'h05);
  endtask : s_input
  task automatic s_cts();
    bus(1, popc_pkg::OFS_ALT_TWO, 0);
    bus(1, popc_pkg::OFS_PULL_UP, 0);
    // A clear-to-send pin with its input buffer off reads as idle high, so listen on all pins
    bus(1, popc_pkg::OFS_INPUT_EN, 32'hFF);
    ext <= 8'h04;
    bus(1, popc_pkg::OFS_ALT_THREE, 32'h44);
    chk({pins.clear_to_send_ch7, pins.clear_to_send_ch6}, 2'h1);
    ext <= 8'h40;
    repeat (2) @(posedge clk);
    chk({pins.clear_to_send_ch7, pins.clear_to_send_ch6}, 2'h2);
  endtask : s_cts
  task automatic final_report();
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    s_regs();
    s_drive();
    s_input();
    s_cts();
    final_report();
  end
  // Watchdog: about twenty-four times the expected run
  initial begin
    #400000;
    errors++;
    final_report();
  end
endmodule : test_popc_port_o
